// ===== rtl/adc_serial_config_port.v
// Serial configuration port of a dual-channel converter, with an AXI4-Lite
// window so on-chip software can see and preset the power-down and mode registers.
// Assumes serial_select_n, the shift clock and the data line come from pins,
// and the sampling-clock presence flag comes from outside the clock domain.
// The shift clock is oversampled, so each of its phases must last at least
// three system clock periods; slower links are always safe.
//
// Behaviour
// RQ1: Bits are shifted in only while the select input is low; otherwise the shift clock is ignored.
// RQ2: While selected, the data line is sampled on every rising shift clock edge.
// RQ3: Every 24th rising edge in one select-low period commits the word to the addressed register.
// RQ4: Trailing bits short of a full frame are dropped with no register change.
// RQ5: Several frames in one select-low period are each handled on their own.
// RQ6: The controller keeps the shift clock at or below 12 MHz; any slower rate and duty cycle works. Here each phase needs three system clock periods.
// RQ7: A write frame has direction 0, three zero bits, a 12-bit address, then 8 data bits.
// RQ8: A read frame has direction 1, three zero bits, then the 12-bit address.
// RQ9: A read frame never updates a register.
// RQ10: During a read frame the addressed register is driven on the data line in the data bit slots.
// RQ11: The controller captures read bits on the falling shift clock edge.
// RQ12: A power-down request from pin or register takes effect only while the sampling clock runs.
// RQ13: Without any programming the block works in its default setup, power-down by pin.
// RQ14: Power-up defaults are bypass, two lanes, two's complement, auto-zero off, external reference, differential.
// RQ15: The data line is driven only in the data phase of a read frame, released otherwise.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "cfg_port_consts.vh"
module adc_serial_config_port #(
   parameter ADDR_W = 12,
   parameter DATA_W = 8
) (
   // Clock and reset.
   input wire clk_sys,
   input wire rst,
   // Serial configuration pins.
   input wire serial_select_n,
   input wire shiftClk,
   input wire dataIn,
   output reg dataOut,
   output reg dataOe_n,
   // Power-down pin and sampling clock presence, both asynchronous.
   input wire powerdown_sync_pin,
   input wire sampleClkPresent,
   // Configuration seen by the converter datapath.
   output wire [DATA_W-1:0] convCfg,
   output reg powerDown,
   output reg softReset,
   // AXI4-Lite slave.
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   // ************************************************************
   // Pin synchronisers and edge detection
   // ************************************************************
   wire selN;
   wire sclk;
   wire sdi;
   wire pdnPin;
   wire clkPresent;
   wire sclkRise;
   wire sclkFall;
   wire selFall;

   pin_sync #(.RESET_VAL(1'b1)) uSyncSel (.clk_sys(clk_sys), .rst(rst), .pinIn(serial_select_n), .levelOut(selN));
   pin_sync #(.RESET_VAL(1'b0)) uSyncClk (.clk_sys(clk_sys), .rst(rst), .pinIn(shiftClk), .levelOut(sclk));
   pin_sync #(.RESET_VAL(1'b0)) uSyncDat (.clk_sys(clk_sys), .rst(rst), .pinIn(dataIn), .levelOut(sdi));
   pin_sync #(.RESET_VAL(1'b0)) uSyncPdn (.clk_sys(clk_sys), .rst(rst), .pinIn(powerdown_sync_pin), .levelOut(pdnPin));
   pin_sync #(.RESET_VAL(1'b0)) uSyncSmp (.clk_sys(clk_sys), .rst(rst), .pinIn(sampleClkPresent), .levelOut(clkPresent));

   edge_finder #(.RESET_VAL(1'b0)) uEdgeClk (.clk_sys(clk_sys), .rst(rst), .level(sclk), .rise(sclkRise), .fall(sclkFall));
   edge_finder #(.RESET_VAL(1'b1)) uEdgeSel (.clk_sys(clk_sys), .rst(rst), .level(selN), .rise(), .fall(selFall));

   // ************************************************************
   // Register storage
   // ************************************************************
   // A small slot file; only a few of the 4096 serial addresses exist.
   // Unmapped serial addresses read as zero and ignore writes.
   reg [DATA_W-1:0] regs_q [0:`SLOT_COUNT-1];
   reg [DATA_W-1:0] regs_d [0:`SLOT_COUNT-1];
   reg serialWrEn;
   reg [ADDR_W-1:0] serialWrAddr;
   reg [DATA_W-1:0] serialWrData;
   reg axiWrEn;
   reg [1:0] axiWrSlot;
   reg [DATA_W-1:0] axiWrData;
   // Power-down byte; bit 0 is the global request from software.
   wire [DATA_W-1:0] pdnReg = regs_q[1];

   // Serial addresses 0x000 and 0x008 share their low bits, so the slot
   // index is decoded explicitly rather than taken from the address bits.
   function [2:0] slotOf;
      input [ADDR_W-1:0] a;
      begin
         case (a)
            `SLOT_PDN: slotOf = 3'd1;
            `SLOT_CFG: slotOf = 3'd6;
            default: slotOf = 3'd0;
         endcase
      end
   endfunction

   function mapped;
      input [ADDR_W-1:0] a;
      begin
         mapped = (a == `SLOT_RESET) || (a == `SLOT_PDN) || (a == `SLOT_CFG);
      end
   endfunction

   // ************************************************************
   // Serial frame receiver
   // ************************************************************
   reg [4:0] bitCnt_q;
   reg [22:0] shift_q;
   reg dirRead_q;
   reg [DATA_W-1:0] readByte_q;
   wire [23:0] frameWord = {shift_q, sdi};

   // Count bits within each select-low period; a new select resets the count,
   // so a trailing partial frame simply never reaches the commit point.
   // The shift register keeps the newest 23 bits, so back-to-back frames need no realignment.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bitCnt_q <= 5'd0;
         shift_q <= 23'h000000;
         dirRead_q <= 1'b0;
         readByte_q <= 8'h00;
      end else if (selN || selFall) begin // [RQ1] [RQ4]
         bitCnt_q <= 5'd0;
         dirRead_q <= 1'b0;
      end else if (sclkRise) begin // [RQ2]
         shift_q <= frameWord[22:0];
         if (bitCnt_q == `FRAME_LAST) begin // [RQ3] [RQ5]
            bitCnt_q <= 5'd0;
            dirRead_q <= 1'b0;
         end else begin
            bitCnt_q <= bitCnt_q + 5'd1;
         end
         if (bitCnt_q == 5'd0) begin
            dirRead_q <= sdi; // [RQ8]
         end
         // Fetch the read byte once the last address bit arrives.
         if (bitCnt_q == (`DATA_FIRST_BIT - 5'd1)) begin // [RQ10]
            readByte_q <= mapped(frameWord[ADDR_W-1:0]) ? regs_q[slotOf(frameWord[ADDR_W-1:0])] : 8'h00;
         end
      end
   end

   // Commit on the 24th rising edge, write frames only.
   always @* begin
      serialWrEn = !selN && sclkRise && (bitCnt_q == `FRAME_LAST) && !frameWord[`DIR_BIT]; // [RQ3] [RQ9]
      serialWrAddr = frameWord[`ADDR_HI:`ADDR_LO]; // [RQ7]
      serialWrData = frameWord[DATA_W-1:0];
   end

   // ************************************************************
   // Read-back driver
   // ************************************************************
   // Bit slot k of the data phase changes after the falling edge before it,
   // so the controller sees a stable bit at its own falling-edge capture.
   // The last bit is held past the 24th rising edge until the falling edge
   // after it; releasing on the rise would pull it away before the capture.
   reg tailDrive_q;
   wire readSlots = dirRead_q && (bitCnt_q >= `DATA_FIRST_BIT);
   wire inDataPhase = !selN && (readSlots || tailDrive_q);
   wire [2:0] bitIdx = 3'd7 - bitCnt_q[2:0];

   // Set on the 24th rise of a read frame, cleared by the next fall or by deselect.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tailDrive_q <= 1'b0;
      end else if (selN || sclkFall) begin
         tailDrive_q <= 1'b0;
      end else if (sclkRise && dirRead_q && (bitCnt_q == `FRAME_LAST)) begin // [RQ10]
         tailDrive_q <= 1'b1;
      end
   end

   // Drive the line only in the data phase; park the value low when released.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dataOut <= 1'b0;
         dataOe_n <= 1'b1;
      end else if (inDataPhase) begin // [RQ15]
         dataOe_n <= 1'b0;
         if (readSlots && (sclkFall || sclkRise)) begin
            dataOut <= readByte_q[bitIdx]; // [RQ10] [RQ11]
         end
      end else begin
         dataOe_n <= 1'b1; // [RQ15]
         dataOut <= 1'b0;
      end
   end

   // ************************************************************
   // AXI4-Lite slave
   // ************************************************************
   reg awHeld_q;
   reg [3:0] awAddr_q;
   reg wHeld_q;
   reg [31:0] wData_q;
   reg [3:0] wStrb_q;

   // Ready stays low while a response waits, so at most one write is in flight.
   assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
   assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   // Address and data may be taken in either order; response follows both.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         awHeld_q <= 1'b0;
         awAddr_q <= 4'h0;
         wHeld_q <= 1'b0;
         wData_q <= 32'h00000000;
         wStrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (awHeld_q && wHeld_q) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddr_q == `AXI_CFG || awAddr_q == `AXI_PDN || awAddr_q == `AXI_CTRL) ? 2'b00 : 2'b10;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Only byte lane 0 carries register data.
   always @* begin
      axiWrEn = awHeld_q && wHeld_q && wStrb_q[0];
      axiWrData = wData_q[7:0];
      case (awAddr_q)
         `AXI_CTRL: axiWrSlot = 2'd0;
         `AXI_CFG: axiWrSlot = 2'd2;
         `AXI_PDN: axiWrSlot = 2'd1;
         default: begin
            axiWrSlot = 2'd3;
            axiWrEn = 1'b0;
         end
      endcase
   end

   // Read channel: status word shows the receiver's live state.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'b00;
         case (s_axi_araddr)
            `AXI_CTRL: s_axi_rdata <= {24'h000000, pdnReg};
            `AXI_STAT: s_axi_rdata <= {24'h000000, powerDown, clkPresent, dirRead_q, bitCnt_q};
            `AXI_CFG: s_axi_rdata <= {24'h000000, regs_q[6]};
            `AXI_PDN: s_axi_rdata <= {24'h000000, pdnReg};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ************************************************************
   // Register update and outputs
   // ************************************************************
   integer i;
   integer j;

   // Serial writes win over a bus write in the same cycle.
   always @* begin
      for (i = 0; i < `SLOT_COUNT; i = i + 1) begin
         regs_d[i] = regs_q[i];
      end
      if (axiWrEn) begin
         case (axiWrSlot)
            // Control and power-down offsets are two views of the same byte.
            2'd0: regs_d[1] = axiWrData;
            2'd1: regs_d[1] = axiWrData;
            default: regs_d[6] = axiWrData;
         endcase
      end
      if (serialWrEn && mapped(serialWrAddr)) begin
         regs_d[slotOf(serialWrAddr)] = serialWrData;
      end
   end

   // Power-up defaults give a working converter with no programming.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (j = 0; j < `SLOT_COUNT; j = j + 1) begin
            regs_q[j] <= 8'h00; // [RQ13] [RQ14]
         end
      end else begin
         for (j = 0; j < `SLOT_COUNT; j = j + 1) begin
            regs_q[j] <= regs_d[j];
         end
      end
   end

   assign convCfg = regs_q[6]; // [RQ14]

   // Power-down only changes while the sampling clock is present; otherwise
   // the previous state is held, matching a converter with nothing to clock.
   // A request that arrives with no sampling clock waits until the clock returns.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         powerDown <= 1'b0;
         softReset <= 1'b0;
      end else begin
         if (clkPresent) begin // [RQ12]
            powerDown <= pdnPin | pdnReg[`PDN_GLOBAL_BIT]; // [RQ13]
         end
         softReset <= serialWrEn && (serialWrAddr == `SLOT_RESET) && serialWrData[0];
      end
   end
endmodule
`default_nettype wire

// ===== rtl/cfg_port_consts.vh
// Constants for the serial configuration port: frame layout, register
// slots, AXI4-Lite offsets, reset values and timing figures.
// Assumes inclusion by the top design file of the configuration port and by the bench.
`ifndef CFG_PORT_CONSTS_VH
`define CFG_PORT_CONSTS_VH

// Frame layout: one direction bit, three zero bits, 12 address bits, 8 data bits.
`define FRAME_BITS 5'd24
`define FRAME_LAST 5'd23
`define DATA_FIRST_BIT 5'd16
`define DIR_BIT 23
`define ADDR_HI 19
`define ADDR_LO 8

// Register slots held inside the port (12-bit serial address).
`define SLOT_COUNT 8
`define SLOT_RESET 12'h000
`define SLOT_PDN 12'h008
`define SLOT_CFG 12'h00E

// Power-up values: converter mode byte encodes bypass, two lanes,
// two's complement, auto-zero off, external reference, differential.
`define CFG_RESET_VAL 8'h00
`define PDN_RESET_VAL 8'h00
`define PDN_GLOBAL_BIT 0

// AXI4-Lite byte offsets.
`define AXI_CTRL 4'h0
`define AXI_STAT 4'h4
`define AXI_CFG 4'h8
`define AXI_PDN 4'hC

// Shift clock ceiling, in MHz, and the system rate in MHz.
`define SCLK_MAX_MHZ 12
`define SYS_MHZ 20
`define SAMPLE_TIMEOUT_NS 1000
`define SAMPLE_TIMEOUT_CYC ((`SAMPLE_TIMEOUT_NS * `SYS_MHZ) / 1000)

`endif

// ===== rtl/pin_sync.v
// Two flip-flop synchroniser for one level from outside the clock domain.
// Assumes the input is free-running relative to clk_sys.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
   parameter RESET_VAL = 1'b0
) (
   // Clock and reset.
   input wire clk_sys,
   input wire rst,
   // Level in and synchronised level out.
   input wire pinIn,
   output wire levelOut
);
   reg meta_q;
   reg sync_q;

   // The first stage is read only by the second one.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         meta_q <= RESET_VAL;
         sync_q <= RESET_VAL;
      end else begin
         meta_q <= pinIn;
         sync_q <= meta_q;
      end
   end

   assign levelOut = sync_q;
endmodule
`default_nettype wire

// ===== rtl/edge_finder.v
// Finds rising and falling edges of an already synchronised level.
// Assumes the input comes from a synchroniser on the same clock.
`timescale 1ns/1ns
`default_nettype none
module edge_finder #(
   parameter RESET_VAL = 1'b0
) (
   // Clock and reset.
   input wire clk_sys,
   input wire rst,
   // Synchronised level and its edge pulses.
   input wire level,
   output wire rise,
   output wire fall
);
   reg last_q;

   // Remember the previous level to compare against.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         last_q <= RESET_VAL;
      end else begin
         last_q <= level;
      end
   end

   assign rise = level & ~last_q;
   assign fall = ~level & last_q;
endmodule
`default_nettype wire

// ===== testbench/serial_host.sv
// Behavioural host controller for the three-wire configuration link.
// Assumes the bench resolves the shared data line and feeds it back on sdio.
`timescale 1ns/1ns
`default_nettype none
module serial_host (
   // Link pins driven by the host.
   output logic selN,
   output logic sclk,
   output logic hostBit,
   // Resolved data line.
   input wire logic sdio
);
   // Idle: deselected, clock parked low between frames.
   initial begin
      selN = 1'b1;
      sclk = 1'b0;
      hostBit = 1'b0;
   end
   // Sends n bits MSB first at 2.5 MHz with a 40/60 duty cycle.
   // In read data slots the host lets go and toggles its own bit, so a silent device shows no stale data.
   task automatic xfer(input logic [47:0] v, input int n, input bit q, output logic [7:0] got);
      bit rd;
      rd = 1'b0;
      got = 8'h00;
      // The 10 ns lead keeps every pin change off the system clock's rising edges.
      #10 selN = q;
      #200;
      for (int i = 0; i < n; i++) begin
         if (i % 24 == 0) rd = v[47 - i];
         hostBit = (rd && i % 24 >= 16) ? ~hostBit : v[47 - i];
         #100 sclk = 1'b1;
         #160 sclk = 1'b0;
         if (rd && i % 24 >= 16) got = {got[6:0], sdio};
         #140;
      end
      #200 selN = 1'b1;
      #400;
   endtask
endmodule
`default_nettype wire

// ===== testbench/cfg_port_chk.sv
// Assertions on the configuration port's pins and bus slave.
// Assumes it is bound to the top module, clocked by clk_sys and reset by rst.
`timescale 1ns/1ns
`default_nettype none
module cfg_port_chk #(
   parameter DATA_W = 8
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // Link and datapath side.
   input wire logic serial_select_n,
   input wire logic dataOe_n,
   input wire logic sampleClkPresent,
   input wire logic powerDown,
   input wire logic softReset,
   input wire logic [DATA_W-1:0] convCfg,
   // Bus side.
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid
);
   // All checks share one domain.
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // Six samples deselected leave room for the select synchroniser.
   a_oe_idle_sel: assert property (serial_select_n [*6] |-> dataOe_n)
      else $error("data line driven while deselected");
   a_oe_in_frame: assert property ($fell(dataOe_n) |-> !serial_select_n)
      else $error("drive began outside a frame");
   a_reset_dflt: assert property ($fell(rst) |-> convCfg == '0 && !powerDown && dataOe_n)
      else $error("power-up defaults wrong");
   a_pdn_frozen: assert property (!sampleClkPresent [*4] |=> $stable(powerDown))
      else $error("power-down moved without sampling clock");
   a_soft_pulse: assert property (softReset |=> !softReset)
      else $error("soft reset longer than one cycle");
   a_cfg_quiet: assert property ($changed(convCfg) |->
      s_axi_bvalid || $past(s_axi_awvalid) || !$past(serial_select_n, 3))
      else $error("mode byte changed with no writer");
   a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write address taken during response");
   a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not retired");
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for the configuration port with a reference model.
// Assumes the host model drives the link and the bench drives the bus.
`timescale 1ns/1ns
`default_nettype none
`include "cfg_port_consts.vh"
module tb;
   logic clk_sys, rst, powerdown_sync_pin, sampleClkPresent;
   logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
   logic [31:0] s_axi_wdata;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   wire logic [7:0] convCfg;
   wire logic dataOut, dataOe_n, powerDown, softReset, serial_select_n, shiftClk, hostBit;
   // The device owns the line only while its enable is low.
   wire logic dataIn = !dataOe_n ? dataOut : hostBit;
   logic [7:0] mdl[int];
   logic [7:0] b;
   logic [31:0] d;
   logic [1:0] r;
   int failures = 0, n_checks = 0, pulses = 0;
   serial_host host (.selN(serial_select_n), .sclk(shiftClk), .hostBit(hostBit), .sdio(dataIn));
   adc_serial_config_port DUT (.clk_sys, .rst, .serial_select_n, .shiftClk, .dataIn, .dataOut,
      .dataOe_n, .powerdown_sync_pin, .sampleClkPresent, .convCfg, .powerDown, .softReset,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   // ************************************************************
   // Tasks and model
   // ************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d, failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   function automatic logic [23:0] wf(input bit rd, input logic [11:0] a, input logic [7:0] v);
      return {rd, 3'b000, a, v};
   endfunction
   // Bus write: both channels offered together, each released when taken.
   task automatic axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
      bit done;
      done = 1'b0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done) begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
   task automatic axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
      bit done;
      done = 1'b0;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
         @(posedge clk_sys);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            v = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
   // Sends a burst, replays whole frames on the model and compares results.
   task automatic frm(input logic [47:0] v, input int n, input bit q);
      logic [23:0] w;
      logic [7:0] got;
      host.xfer(v, n, q, got);
      @(posedge clk_sys);
      for (int k = 0; k < n / 24 && !q; k++) begin
         w = v[47 - 24 * k -: 24];
         if (!w[23]) mdl[w[19:8]] = w[7:0];
         else chk(got, mdl[w[19:8]]);
      end
      chk(convCfg, mdl[14]);
      chk(powerDown, mdl[8][0]);
   endtask
   // Free-running system clock.
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // Soft reset pulses seen at the port.
   always @(posedge clk_sys) if (softReset === 1'b1) pulses <= pulses + 1;
   // Watchdog sized well beyond the dozen frames of the run.
   initial begin
      #1000000;
      failures++;
      end_sim;
   end
   // Main sequence.
   initial begin
      void'($urandom(32'hFBBF9C69));
      {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
      {powerdown_sync_pin, sampleClkPresent, s_axi_awaddr, s_axi_araddr} = 10'h100;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      mdl[8] = `PDN_RESET_VAL;
      mdl[14] = `CFG_RESET_VAL;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk(convCfg, 8'h00);
      chk(powerDown, 1'b0);
      axr(`AXI_CFG, d, r);
      chk(d, 32'h0);
      $display("defaults done");
      // A write then a read in one select period; the read must not write.
      repeat (3) begin
         b = $urandom;
         frm({wf(1'b0, 12'h00E, b), wf(1'b1, 12'h00E, ~b)}, 48, 1'b0);
      end
      b = $urandom;
      frm({wf(1'b0, 12'h00E, b), wf(1'b0, 12'h00E, ~b)}, 37, 1'b0);
      frm({wf(1'b0, 12'h00E, ~b), 24'h0}, 24, 1'b1);
      $display("serial frames done");
      // Pin power-down, frozen while the sampling clock is absent.
      powerdown_sync_pin <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk(powerDown, 1'b1);
      sampleClkPresent <= 1'b0;
      powerdown_sync_pin <= 1'b0;
      repeat (8) @(posedge clk_sys);
      chk(powerDown, 1'b1);
      sampleClkPresent <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk(powerDown, 1'b0);
      frm({wf(1'b0, 12'h008, 8'h01), wf(1'b1, 12'h008, 8'h00)}, 48, 1'b0);
      axr(`AXI_PDN, d, r);
      chk(d, 32'h1);
      axw(`AXI_CTRL, 32'h0, r);
      mdl[8] = 8'h00;
      repeat (4) @(posedge clk_sys);
      chk(powerDown, 1'b0);
      $display("power-down done");
      // Bus side writes the mode byte; serial read must echo it.
      b = $urandom;
      axw(`AXI_CFG, {24'h0, b}, r);
      mdl[14] = b;
      chk(r, 2'b00);
      axr(4'h2, d, r);
      chk(r, 2'b10);
      frm({wf(1'b1, 12'h00E, 8'h00), 24'h0}, 24, 1'b0);
      $display("bus done");
      // Soft reset last, since it may clear the other registers.
      host.xfer({wf(1'b0, 12'h000, 8'h01), 24'h0}, 24, 1'b0, b);
      chk(pulses, 32'd1);
      $display("soft reset done");
      end_sim;
   end
endmodule
bind adc_serial_config_port cfg_port_chk #(.DATA_W(DATA_W)) chk (.clk_sys, .rst, .serial_select_n,
   .dataOe_n, .sampleClkPresent, .powerDown, .softReset, .convCfg, .s_axi_awvalid, .s_axi_awready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire
